// ===== core/ppfm_pkg.sv
// Shared types and constants for the port pin function multiplexer
package ppfm_pkg;

   // Operating modes, one-hot, captured at reset release
   typedef enum logic [3:0] {
      PPFM_MODE_SINGLE = 4'h1,
      PPFM_MODE_EXPAND = 4'h2,
      PPFM_MODE_BOOT   = 4'h4,
      PPFM_MODE_TEST   = 4'h8
   } ppfm_mode_t;

   // Mode strap codes, high select bit first
   localparam logic [1:0] PPFM_STRAP_SINGLE = 2'h2;
   localparam logic [1:0] PPFM_STRAP_EXPAND = 2'h3;
   localparam logic [1:0] PPFM_STRAP_BOOT   = 2'h0;
   localparam logic [1:0] PPFM_STRAP_TEST   = 2'h1;

   localparam ppfm_mode_t PPFM_MODE_RST = PPFM_MODE_SINGLE;
   localparam int         PPFM_PORT_W   = 8;

   // Two-signal view of an 8-bit group of two-way pins
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe;
   } ppfm_pins_t;

   // Expansion bus request from the core side
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        rd_wr_n;
      logic        addr_phase;
      logic        data_phase;
   } ppfm_bus_t;

   // Timer alternate functions on port A
   typedef struct packed {
      logic [3:0] cmp_out;    // Bit 0 is compare_out_2 ... bit 3 is compare_out_5
      logic [3:0] cmp_en;
      logic       cmp1_out;
      logic [4:0] cmp1_en;    // Bit 0 drives pin 3 ... bit 4 drives pin 7
      logic       cmp1_on_7;  // Pin 7 output enabled; pulse_accum_in still reads pin 7
   } ppfm_timer_t;

endpackage

// ===== core/ppfm_sync2.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module ppfm_sync2 #(
   parameter int W = 8
) (
   input  wire logic         clk,     // System clock
   input  wire logic         sys_rst, // Asynchronous reset, active high
   input  wire logic [W-1:0] d,       // Asynchronous input
   output logic      [W-1:0] q        // Synchronised output
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ===== core/ppfm_mux.sv
// Pin function multiplexer for ports A to E and the two strobe pins
`timescale 1ns/1ps
// What this block does
// RQ1: Port A, D and E functions never depend on the operating mode.
// RQ2: Single-chip and bootstrap modes make port B eight general outputs.
// RQ3: Expanded and test modes drive address bits 8..15 onto port B pins 0..7.
// RQ4: Single-chip and bootstrap modes make port C eight two-way general lines.
// RQ5: Expanded and test modes use port C pin n as address/data bit n.
// RQ6: Port A pins 0,1,2 feed capture inputs 3,2,1 in every mode.
// RQ7: Port A 3..6 carry compare 5..2; pin 7 pulse input or compare 1.
// RQ8: Port C carries low address, then data while E high; strobe latches address.
// RQ9: Mode pins set mode at reset: 10 single, 11 expanded, 00 boot, 01 test.
// RQ10: Mode is caught at reset release and held until the next reset.
module ppfm_mux (
   input  wire logic                 clk,              // System clock, 250 MHz
   input  wire logic                 sys_rst,          // Asynchronous reset, active high
   input  wire logic                 mode_select_high, // Mode strap, high bit
   input  wire logic                 mode_select_low,  // Mode strap, low bit
   // Port A
   input  wire logic [7:0]           pa_in,            // Port A pin levels
   output logic      [7:0]           pa_out,           // Port A pin drive
   output logic      [7:0]           pa_oe,            // Port A output enables
   input  wire logic [7:0]           pa_gp_dout,       // Port A general data out
   input  wire logic [7:0]           pa_gp_oe,         // Port A general direction
   output logic      [7:0]           pa_gp_din,        // Port A general data in
   input  wire ppfm_pkg::ppfm_timer_t tmr,             // Timer compare requests
   output logic                      capture_in_1,     // Capture channel 1 input
   output logic                      capture_in_2,     // Capture channel 2 input
   output logic                      capture_in_3,     // Capture channel 3 input
   output logic                      pulse_accum_in,   // Pulse accumulator input
   // Port B
   output logic      [7:0]           pb_out,           // Port B pin drive
   input  wire logic [7:0]           pb_gp_dout,       // Port B general data out
   // Port C
   input  wire logic [7:0]           pc_in,            // Port C pin levels
   output logic      [7:0]           pc_out,           // Port C pin drive
   output logic      [7:0]           pc_oe,            // Port C output enables
   input  wire logic [7:0]           pc_gp_dout,       // Port C general data out
   input  wire logic [7:0]           pc_gp_oe,         // Port C general direction
   output logic      [7:0]           pc_gp_din,        // Port C general data in
   // Strobe pins
   input  wire logic                 handshake_strobe_in_in,          // Strobe A pin level
   output logic                      handshake_strobe_in_out,         // Strobe A pin drive
   output logic                      handshake_strobe_in_oe,          // Strobe A output enable
   output logic                      handshake_strobe_in, // Handshake strobe to core
   output logic                      handshake_strobe_out_out,         // Strobe B / read-write pin
   input  wire logic                 handshake_strobe_out, // Handshake strobe from core
   // Expansion bus
   input  wire ppfm_pkg::ppfm_bus_t  bus,              // Core bus cycle
   output logic      [7:0]           bus_rdata,        // Read data sampled in data phase
   // Ports D and E
   input  wire logic [5:0]           pd_in,            // Port D pin levels
   output logic      [5:0]           pd_out,           // Port D pin drive
   output logic      [5:0]           pd_oe,            // Port D output enables
   input  wire logic [5:0]           pd_alt_dout,      // Serial blocks data out
   input  wire logic [5:0]           pd_alt_oe,        // Serial blocks direction
   output logic      [5:0]           pd_alt_din,       // Serial blocks data in
   input  wire logic [7:0]           pe_in,            // Port E pin levels
   output logic      [7:0]           pe_din,           // Port E to general and converter
   output ppfm_pkg::ppfm_mode_t      mode,             // Held operating mode
   output logic                      bus_mode          // Expansion pins active
);
   ppfm_pkg::ppfm_mode_t mode_r;
   logic [2:0]           cap_pend_r;
   logic [7:0]           pa_s, pc_s, pe_s;
   logic [5:0]           pd_s;
   logic [1:0]           strap_s;
   logic                 handshake_strobe_in_s;
   logic [7:0]           pa_drv, pa_en;

   // All pin inputs come from outside the clock domain
   ppfm_sync2 #(.W(33)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({pa_in, pc_in, pe_in, pd_in, mode_select_high, mode_select_low, handshake_strobe_in_in}),
      .q       ({pa_s, pc_s, pe_s, pd_s, strap_s, handshake_strobe_in_s})
   );

   // Synced straps settle two edges after release; decode on the third so
   // the mode never comes from a synchroniser still holding its reset value
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cap_pend_r <= 3'h4;
      end else begin
         cap_pend_r <= {1'b0, cap_pend_r[2:1]};
      end
   end

   // Straps are taken once per reset and then frozen
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_r <= ppfm_pkg::PPFM_MODE_RST;
      end else if (cap_pend_r[0]) begin // RQ10
         case (strap_s) // RQ9
            ppfm_pkg::PPFM_STRAP_SINGLE: mode_r <= ppfm_pkg::PPFM_MODE_SINGLE;
            ppfm_pkg::PPFM_STRAP_EXPAND: mode_r <= ppfm_pkg::PPFM_MODE_EXPAND;
            ppfm_pkg::PPFM_STRAP_BOOT:   mode_r <= ppfm_pkg::PPFM_MODE_BOOT;
            ppfm_pkg::PPFM_STRAP_TEST:   mode_r <= ppfm_pkg::PPFM_MODE_TEST;
            default:                     mode_r <= ppfm_pkg::PPFM_MODE_RST;
         endcase
      end
   end

   assign mode     = mode_r;
   assign bus_mode = (mode_r == ppfm_pkg::PPFM_MODE_EXPAND) ||
                     (mode_r == ppfm_pkg::PPFM_MODE_TEST);

   // Port A: timer pins are wired the same regardless of mode
   always_comb begin
      pa_drv = pa_gp_dout;
      pa_en  = pa_gp_oe;
      for (int i = 0; i < 4; i++) begin
         if (tmr.cmp_en[i]) begin // RQ7
            pa_drv[6-i] = tmr.cmp_out[i];
            pa_en[6-i]  = 1'b1;
         end
      end
      if (tmr.cmp1_on_7) begin // RQ7
         pa_en[7] = 1'b1;
      end
      // Compare 1 overrides the others where enabled, as it may share a pin
      for (int i = 0; i < 5; i++) begin
         if (tmr.cmp1_en[i]) begin // RQ7
            pa_drv[3+i] = tmr.cmp1_out;
            pa_en[3+i]  = 1'b1;
         end
      end
      pa_en[2:0] = pa_gp_oe[2:0];
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pa_out <= 8'h00;
         pa_oe  <= 8'h00;
      end else begin
         pa_out <= pa_drv; // RQ1
         pa_oe  <= pa_en;
      end
   end

   assign pa_gp_din      = pa_s;
   assign capture_in_3   = pa_s[0]; // RQ6
   assign capture_in_2   = pa_s[1]; // RQ6
   assign capture_in_1   = pa_s[2]; // RQ6
   assign pulse_accum_in = pa_s[7]; // RQ7

   // Port B is output-only in every mode
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pb_out <= 8'h00;
      end else if (bus_mode) begin
         pb_out <= bus.addr[15:8]; // RQ3
      end else begin
         pb_out <= pb_gp_dout; // RQ2
      end
   end

   // Port C: general I/O, or address then data with direction from read-write
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pc_out <= 8'h00;
         pc_oe  <= 8'h00;
      end else if (!bus_mode) begin
         pc_out <= pc_gp_dout; // RQ4
         pc_oe  <= pc_gp_oe;
      end else if (bus.addr_phase) begin
         pc_out <= bus.addr[7:0]; // RQ5 RQ8
         pc_oe  <= 8'hFF;
      end else if (bus.data_phase) begin
         pc_out <= bus.wdata; // RQ8
         pc_oe  <= bus.rd_wr_n ? 8'h00 : 8'hFF;
      end else begin
         pc_out <= 8'h00;
         pc_oe  <= 8'h00;
      end
   end

   assign pc_gp_din = bus_mode ? 8'h00 : pc_s;

   // Read data is the synchronised pin level, sampled in read data phases
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_rdata <= 8'h00;
      end else if (bus_mode && bus.data_phase && bus.rd_wr_n) begin
         bus_rdata <= pc_s; // RQ8
      end
   end

   // Strobe pins: address strobe and read-write in bus modes, handshake otherwise
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         handshake_strobe_in_out <= 1'b0;
         handshake_strobe_in_oe  <= 1'b0;
         handshake_strobe_out_out <= 1'b0;
      end else if (bus_mode) begin
         handshake_strobe_in_out <= bus.addr_phase; // RQ8
         handshake_strobe_in_oe  <= 1'b1;
         handshake_strobe_out_out <= bus.rd_wr_n;
      end else begin
         handshake_strobe_in_out <= 1'b0;
         handshake_strobe_in_oe  <= 1'b0;
         handshake_strobe_out_out <= handshake_strobe_out;
      end
   end

   assign handshake_strobe_in = bus_mode ? 1'b0 : handshake_strobe_in_s;

   // Ports D and E pass straight to their alternate functions
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pd_out <= 6'h00;
         pd_oe  <= 6'h00;
      end else begin
         pd_out <= pd_alt_dout; // RQ1
         pd_oe  <= pd_alt_oe;
      end
   end

   assign pd_alt_din = pd_s; // RQ1
   assign pe_din     = pe_s; // RQ1
endmodule

// ===== verif/ppfm_mux_chk.sv
// Port-level assertions for the pin function multiplexer
`timescale 1ns/1ps
module ppfm_mux_chk (
   input wire logic                  clk,              // Clock
   input wire logic                  sys_rst,          // Reset
   input wire logic                  mode_select_high, // Strap high
   input wire logic                  mode_select_low,  // Strap low
   input wire logic [7:0]            pa_in,            // Port A level
   input wire logic [7:0]            pa_out,           // Port A drive
   input wire ppfm_pkg::ppfm_timer_t tmr,              // Timer requests
   input wire logic                  capture_in_1,     // Capture 1
   input wire logic                  capture_in_2,     // Capture 2
   input wire logic                  capture_in_3,     // Capture 3
   input wire logic [7:0]            pb_out,           // Port B drive
   input wire logic [7:0]            pb_gp_dout,       // Port B data
   input wire logic [7:0]            pc_out,           // Port C drive
   input wire logic [7:0]            pc_oe,            // Port C enable
   input wire logic [7:0]            pc_gp_dout,       // Port C data
   input wire logic [7:0]            pc_gp_oe,         // Port C direction
   input wire logic                  handshake_strobe_in_out,         // Address strobe
   input wire logic                  handshake_strobe_out_out,         // Read/write
   input wire ppfm_pkg::ppfm_bus_t   bus,              // Bus cycle
   input wire logic [5:0]            pd_out,           // Port D drive
   input wire logic [5:0]            pd_alt_dout,      // Serial data
   input wire logic [7:0]            pe_in,            // Port E level
   input wire logic [7:0]            pe_din,           // Port E synced
   input wire ppfm_pkg::ppfm_mode_t  mode,             // Held mode
   input wire logic                  bus_mode          // Bus pins active
);
   // Straps map to a one-hot bit index without a lookup table
   wire [1:0] strap_idx = {~mode_select_high, mode_select_low};
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_mode_strap: assert property ($fell(sys_rst) |-> ##3
      mode == (4'h1 << $past(strap_idx, 3)) && bus_mode == $past(mode_select_low, 3))
      else $error("mode not taken from straps");
   chk_mode_held: assert property (!$past(sys_rst) && !$past(sys_rst, 2) &&
      !$past(sys_rst, 3) && !$past(sys_rst, 4) |-> $stable(mode))
      else $error("mode changed outside reset");
   chk_pb_gp_out: assert property (!bus_mode ##1 !bus_mode |-> pb_out == $past(pb_gp_dout))
      else $error("port B not general output");
   chk_pb_high_addr: assert property (bus_mode && bus.addr_phase |=>
      pb_out == $past(bus.addr[15:8]))
      else $error("port B not high address");
   chk_pc_gp_io: assert property (!bus_mode ##1 !bus_mode |->
      pc_out == $past(pc_gp_dout) && pc_oe == $past(pc_gp_oe))
      else $error("port C not general I/O");
   chk_pc_low_addr: assert property (bus_mode && bus.addr_phase |=>
      pc_out == $past(bus.addr[7:0]) && &pc_oe && handshake_strobe_in_out)
      else $error("port C not low address");
   chk_pc_wr_data: assert property (bus_mode && bus.data_phase && !bus.rd_wr_n |=>
      pc_out == $past(bus.wdata) && &pc_oe && !handshake_strobe_in_out && !handshake_strobe_out_out)
      else $error("port C write data wrong");
   chk_pc_rd_float: assert property (bus_mode && bus.data_phase && bus.rd_wr_n |=>
      pc_oe == 8'h00 && handshake_strobe_out_out)
      else $error("port C not released on read");
   chk_capture_map: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
      {capture_in_1, capture_in_2, capture_in_3} == $past(pa_in[2:0], 2)
      && pe_din == $past(pe_in, 2))
      else $error("capture or port E routing wrong");
   chk_port_d_pass: assert property (!$past(sys_rst) |-> pd_out == $past(pd_alt_dout))
      else $error("port D drive wrong");
   chk_cmp_pins: assert property (tmr.cmp_en == 4'hF && tmr.cmp1_en == 5'h00 |=>
      pa_out[3] == $past(tmr.cmp_out[3]) && pa_out[6] == $past(tmr.cmp_out[0]))
      else $error("compare outputs misplaced");
endmodule
bind ppfm_mux ppfm_mux_chk u_chk (.*);

// ===== verif/ppfm_ext_mem.sv
// External memory on the multiplexed expansion bus
`timescale 1ns/1ps
module ppfm_ext_mem (
   input  wire logic       clk,    // Clock
   input  wire logic [7:0] pb_pin, // High address
   input  wire logic [7:0] pc_pin, // Port C wire level
   input  wire logic [7:0] pc_oe,  // Multiplexer output enables on port C
   input  wire logic       as_pin, // Address strobe
   input  wire logic       rw_pin, // High for read
   output logic      [7:0] pc_drv  // Level offered on port C
);
   logic [15:0] addr_r;
   logic [7:0]  mem [256];
   logic [7:0]  cnt_r = 8'h00;
   always_ff @(posedge clk) begin
      cnt_r <= cnt_r + 8'h01;
      if (as_pin)
         addr_r <= {pb_pin, pc_pin};
      else if (!rw_pin && &pc_oe)
         mem[addr_r[7:0]] <= pc_pin;
   end
   // Released read shows memory; any other cycle a moving pattern so a stale byte never passes
   assign pc_drv = (rw_pin && pc_oe == 8'h00) ? mem[addr_r[7:0]] : cnt_r;
endmodule

// ===== verif/ppfm_mux_tb_top.sv
// Directed testbench for the pin function multiplexer
`timescale 1ns/1ps
module ppfm_mux_tb_top;
   logic clk, sys_rst, mode_select_high, mode_select_low, handshake_strobe_in_in, handshake_strobe_out, is_bus;
   logic [7:0] pa_in, pa_gp_dout, pa_gp_oe, pb_gp_dout, pc_gp_dout, pc_gp_oe, pe_in, tb_pc;
   logic [5:0] pd_in, pd_alt_dout, pd_alt_oe;
   ppfm_pkg::ppfm_timer_t tmr;
   ppfm_pkg::ppfm_bus_t   bus;
   ppfm_pkg::ppfm_mode_t  mode;
   wire [7:0] pa_out, pa_oe, pa_gp_din, pb_out, pc_out, pc_oe, pc_gp_din, bus_rdata, pe_din, mem_d;
   wire [5:0] pd_out, pd_oe, pd_alt_din;
   wire capture_in_1, capture_in_2, capture_in_3, pulse_accum_in, handshake_strobe_in_out, handshake_strobe_in_oe;
   wire handshake_strobe_in, handshake_strobe_out_out, bus_mode;
   wire [7:0] pc_in = (pc_out & pc_oe) | ((is_bus ? mem_d : tb_pc) & ~pc_oe);
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   ppfm_mux u_dut (.*);
   ppfm_ext_mem u_mem (.clk(clk), .pb_pin(pb_out), .pc_pin(pc_in), .pc_oe(pc_oe),
      .as_pin(handshake_strobe_in_out), .rw_pin(handshake_strobe_out_out), .pc_drv(mem_d));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         miscompares++;
         tally_and_finish;
      end
   end
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset(logic [1:0] s);
      {mode_select_high, mode_select_low} = s;
      is_bus = s[0];
      sys_rst = 1'b1;
      cyc(3);
      sys_rst = 1'b0;
      cyc(3);
      chk("mode", 16'(mode), 16'h1 << {~s[1], s[0]});
      chk("bus_mode", 16'(bus_mode), 16'(s[0]));
      // Straps flip now; the held mode must ignore them
      {mode_select_high, mode_select_low} = ~s;
   endtask
   task automatic t_gpio;
      pb_gp_dout = 8'hA5;
      pc_gp_dout = 8'h3C;
      pc_gp_oe = 8'h0F;
      tb_pc = 8'h96;
      handshake_strobe_in_in = 1'b1;
      handshake_strobe_out = 1'b1;
      bus.addr = 16'h1234;
      bus.addr_phase = 1'b1;
      cyc(3);
      chk("pb_out", 16'(pb_out), 16'h00A5);
      chk("pc_oe", 16'(pc_oe), 16'h000F);
      chk("pc_gp_din", 16'(pc_gp_din), 16'h009C);
      chk("hs_in", 16'(handshake_strobe_in), 16'h0001);
      chk("handshake_strobe_out", 16'(handshake_strobe_out_out), 16'h0001);
      chk("handshake_strobe_in_oe", 16'(handshake_strobe_in_oe), 16'h0000);
      bus = '0;
   endtask
   task automatic t_bus;
      bus = '0;
      bus.addr = 16'hC35A;
      bus.addr_phase = 1'b1;
      cyc(1);
      chk("pb_addr", 16'(pb_out), 16'h00C3);
      chk("pc_addr", 16'(pc_out), 16'h005A);
      chk("as", 16'(handshake_strobe_in_out), 16'h0001);
      chk("as_oe", 16'(handshake_strobe_in_oe), 16'h0001);
      chk("hs_in_bus", 16'(handshake_strobe_in), 16'h0000);
      chk("pc_gp_din_bus", 16'(pc_gp_din), 16'h0000);
      bus.addr_phase = 1'b0;
      bus.data_phase = 1'b1;
      bus.wdata = 8'h69;
      cyc(1);
      chk("pc_wdata", 16'(pc_out), 16'h0069);
      chk("rw_wr", 16'(handshake_strobe_out_out), 16'h0000);
      bus.data_phase = 1'b0;
      cyc(1);
      bus.addr_phase = 1'b1;
      bus.rd_wr_n = 1'b1;
      cyc(1);
      bus.addr_phase = 1'b0;
      bus.data_phase = 1'b1;
      cyc(5);
      chk("pc_oe_rd", 16'(pc_oe), 16'h0000);
      chk("rdata", 16'(bus_rdata), 16'h0069);
      bus = '0;
      cyc(1);
   endtask
   task automatic t_alt;
      pa_in = 8'h83;
      pe_in = 8'hB4;
      pd_in = 6'h15;
      pd_alt_dout = 6'h2A;
      pd_alt_oe = 6'h3F;
      tmr = '0;
      tmr.cmp_en = 4'hF;
      tmr.cmp_out = 4'h1;
      cyc(3);
      chk("capture", 16'({capture_in_1, capture_in_2, capture_in_3}), 16'h0003);
      chk("pai", 16'(pulse_accum_in), 16'h0001);
      chk("cmp", 16'({pa_oe[6:3], pa_out[6:3]}), 16'h00F8);
      chk("pe_din", 16'(pe_din), 16'h00B4);
      chk("pd", 16'({pd_alt_din, pd_out}), 16'h056A);
      chk("pd_oe", 16'(pd_oe), 16'h003F);
      chk("pa_gp_din", 16'(pa_gp_din), 16'h0083);
      tmr.cmp1_en = 5'h10;
      tmr.cmp1_out = 1'b1;
      tmr.cmp1_on_7 = 1'b1;
      cyc(1);
      chk("cmp1_pin7", 16'({pa_oe[7], pa_out[7]}), 16'h0003);
   endtask
   initial begin
      sys_rst = 1'b1;
      {mode_select_high, mode_select_low, handshake_strobe_in_in, handshake_strobe_out, is_bus} = '0;
      {pa_in, pa_gp_dout, pa_gp_oe, pb_gp_dout, pc_gp_dout, pc_gp_oe, pe_in, tb_pc} = '0;
      {pd_in, pd_alt_dout, pd_alt_oe} = '0;
      tmr = '0;
      bus = '0;
      for (int i = 0; i < 4; i++) begin
         do_reset(i[1:0]);
         if (i[0])
            t_bus;
         else
            t_gpio;
         t_alt;
         chk("mode_hold", 16'(mode), 16'h1 << {~i[1], i[0]});
      end
      tally_and_finish;
   end
endmodule
